//--- ccp_trigger_postscale_control.sv
// Capture/compare register set with trigger, one-shot, postscaler and sync control
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "ccp_params.svh"

module ccp_trigger_postscale_control #(
  parameter int ADDR_W = 8,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [31:0] busRdata,
  input wire logic trigIn,
  input wire logic captureIn,
  input wire logic altSyncIn,
  output logic intOut,
  output logic syncOut,
  output logic specialEvt,
  output logic trigActive
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // ==========================================================
  // Register storage
  logic [31:0] ctrlOne_r, ctrlTwo_r, ctrlThree_r;
  logic [31:0] counter_r, period_r, compare_r;
  logic [31:0] rdData_r;
  logic [31:0] capMem [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_r, rdPtr_r;
  logic [PTR_W:0] fifoCnt_r;
  logic overflow_r;
  logic [3:0] postCnt_r;
  logic [2:0] shotCnt_r;
  ccp_pkg::trigState_t trigState_r;
  logic intOut_r, syncOut_r, specialEvt_r;

  ccp_pkg::ctrlOne_t ctl;
  ccp_pkg::busOp_t busOp;
  logic [7:0] regBase;
  logic enabled, running, periodMatch, compareMatch, trigStart;
  logic postEvt, postWrap, fifoFull, fifoEmpty, capPush, capPop;
  logic [3:0] postLimit;
  logic [2:0] shotLimit;
  logic [31:0] statusWord;

  assign ctl = ccp_pkg::ctrlOne_t'(ctrlOne_r);
  assign busOp = ccp_pkg::busOp_t'(busAddr[3:2]);
  assign regBase = {busAddr[7:4], 4'h0};

  function automatic logic [31:0] applyOp(input logic [31:0] old, input logic [31:0] wd,
                                          input ccp_pkg::busOp_t op);
    logic [31:0] res;
    res = wd;
    unique case (op)
      ccp_pkg::BUS_WRITE: res = wd;
      ccp_pkg::BUS_CLEAR: res = old & ~wd;
      ccp_pkg::BUS_SET: res = old | wd;
      ccp_pkg::BUS_INVERT: res = old ^ wd;
    endcase
    return res;
  endfunction

  function automatic logic hitWr(input logic [7:0] base, input logic [7:0] off, input logic stb);
    return stb && (base == off);
  endfunction

  // ==========================================================
  // Time base conditions
  assign enabled = ctl.modEnable;
  assign running = enabled && (!ctl.triggered_enable || trigState_r == ccp_pkg::TB_TRIGGERED);
  assign periodMatch = running && (counter_r == period_r);
  assign compareMatch = running && (counter_r == compare_r);
  // Retrigger only counts once triggered operation is on
  assign trigStart = enabled && ctl.triggered_enable && trigIn &&
                     (trigState_r == ccp_pkg::TB_FREE || ctl.retrigEn);
  assign shotLimit = ctrlThree_r[`SHOT_CNT_LSB +: 3];

  // Capture mode counts captures and disregards the source select
  assign postEvt = ctl.capSel ? (enabled && captureIn) :
                   (ctl.postscaler_source_select ? compareMatch : periodMatch);
  assign postLimit = ctl.capSel ? {2'b00, ctl.postScale[1:0]} : ctl.postScale;
  // A limit lowered mid-count must not leave the count stranded above it
  assign postWrap = postEvt && (postCnt_r >= postLimit);

  assign fifoFull = (fifoCnt_r == (PTR_W+1)'(FIFO_DEPTH));
  assign fifoEmpty = (fifoCnt_r == '0);
  assign capPush = enabled && ctl.capSel && captureIn && !fifoFull;
  // Alias reads return zero, so they must not consume a capture either
  assign capPop = busRead && (busOp == ccp_pkg::BUS_WRITE) && (regBase == `OFF_CAPBUF) && !fifoEmpty;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`STAT_TRIG] = (trigState_r == ccp_pkg::TB_TRIGGERED);
    statusWord[`STAT_OVERFLOW] = overflow_r;
    statusWord[`STAT_NOT_EMPTY] = !fifoEmpty;
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrlOne_r <= `RST_CTRL_ONE;
    end else if (hitWr(regBase, `OFF_CTRL_ONE, busWrite)) begin
      ctrlOne_r <= applyOp(ctrlOne_r, busWdata, busOp) & `MASK_CTRL_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrlTwo_r <= `RST_CTRL_TWO;
      ctrlThree_r <= `RST_CTRL_THREE;
    end else begin
      if (hitWr(regBase, `OFF_CTRL_TWO, busWrite)) begin
        ctrlTwo_r <= applyOp(ctrlTwo_r, busWdata, busOp);
      end
      if (hitWr(regBase, `OFF_CTRL_THREE, busWrite)) begin
        ctrlThree_r <= applyOp(ctrlThree_r, busWdata, busOp);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      period_r <= `RST_PERIOD;
      compare_r <= 32'h0000_0000;
    end else begin
      if (hitWr(regBase, `OFF_PERIOD, busWrite)) begin
        period_r <= applyOp(period_r, busWdata, busOp);
      end
      if (hitWr(regBase, `OFF_COMPARE, busWrite)) begin
        compare_r <= applyOp(compare_r, busWdata, busOp);
      end
    end
  end

  // ==========================================================
  // Time-base counter; a software write wins over counting
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      counter_r <= 32'h0000_0000;
    end else if (hitWr(regBase, `OFF_COUNTER, busWrite)) begin
      counter_r <= applyOp(counter_r, busWdata, busOp);
    end else if (trigStart) begin
      counter_r <= 32'h0000_0000;
    end else if (periodMatch) begin
      counter_r <= 32'h0000_0000;
    end else if (running) begin
      counter_r <= counter_r + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Trigger status and one-shot length
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      trigState_r <= ccp_pkg::TB_FREE;
      shotCnt_r <= 3'h0;
    end else if (!enabled || !ctl.triggered_enable) begin
      trigState_r <= ccp_pkg::TB_FREE;
      shotCnt_r <= 3'h0;
    end else if (trigStart) begin
      trigState_r <= ccp_pkg::TB_TRIGGERED;
      shotCnt_r <= 3'h0;
    end else if (periodMatch && ctl.oneShotEn) begin
      if (shotCnt_r == shotLimit) begin
        trigState_r <= ccp_pkg::TB_FREE;
        shotCnt_r <= 3'h0;
      end else begin
        shotCnt_r <= shotCnt_r + 3'h1;
      end
    end
  end

  // ==========================================================
  // Postscaler and outputs
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      postCnt_r <= 4'h0;
    end else if (!enabled) begin
      postCnt_r <= 4'h0;
    end else if (postWrap) begin
      postCnt_r <= 4'h0;
    end else if (postEvt) begin
      postCnt_r <= postCnt_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      intOut_r <= 1'b0;
      syncOut_r <= 1'b0;
      specialEvt_r <= 1'b0;
    end else begin
      intOut_r <= enabled && postWrap;
      syncOut_r <= enabled && (ctl.alternate_sync_select ? altSyncIn : (periodMatch || trigStart));
      specialEvt_r <= compareMatch && !ctl.capSel;
    end
  end

  // ==========================================================
  // Capture FIFO; overflow is sticky until the module is disabled
  always_ff @(posedge sys_clk) begin
    if (capPush) begin
      capMem[wrPtr_r] <= counter_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || !enabled) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fifoCnt_r <= '0;
      overflow_r <= 1'b0;
    end else begin
      if (capPush) begin
        wrPtr_r <= wrPtr_r + PTR_W'(1);
      end
      if (capPop) begin
        rdPtr_r <= rdPtr_r + PTR_W'(1);
      end
      if (capPush && !capPop) begin
        fifoCnt_r <= fifoCnt_r + (PTR_W+1)'(1);
      end else if (capPop && !capPush) begin
        fifoCnt_r <= fifoCnt_r - (PTR_W+1)'(1);
      end
      if (ctl.capSel && captureIn && fifoFull) begin
        overflow_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdData_r <= 32'h0000_0000;
    end else if (busRead && busOp == ccp_pkg::BUS_WRITE) begin
      unique case (regBase)
        `OFF_CTRL_ONE: rdData_r <= ctrlOne_r;
        `OFF_CTRL_TWO: rdData_r <= ctrlTwo_r;
        `OFF_CTRL_THREE: rdData_r <= ctrlThree_r;
        `OFF_STATUS: rdData_r <= statusWord;
        `OFF_COUNTER: rdData_r <= counter_r;
        `OFF_PERIOD: rdData_r <= period_r;
        `OFF_COMPARE: rdData_r <= compare_r;
        `OFF_CAPBUF: rdData_r <= fifoEmpty ? 32'h0000_0000 : capMem[rdPtr_r];
        default: rdData_r <= 32'h0000_0000;
      endcase
    end else begin
      rdData_r <= 32'h0000_0000;
    end
  end

  assign busRdata = rdData_r;
  assign intOut = intOut_r;
  assign syncOut = syncOut_r;
  assign specialEvt = specialEvt_r;
  assign trigActive = (trigState_r == ccp_pkg::TB_TRIGGERED);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic tmrWr;
  assign tmrWr = hitWr(regBase, `OFF_COUNTER, busWrite);

  sequence trigFire;
    trigStart && !tmrWr ##1 trigActive && counter_r == 32'h0000_0000;
  endsequence

  sequence rollOver;
    periodMatch && !tmrWr && !trigStart ##1 counter_r == 32'h0000_0000;
  endsequence

  reservedZero_a: assert property (ctrlOne_r[29:28] == 2'b00 && ctrlOne_r[14] == 1'b0)
    else $error("reserved control bits not zero");

  aliasSet_a: assert property (busWrite && regBase == `OFF_CTRL_TWO && busOp == ccp_pkg::BUS_SET
    |=> ctrlTwo_r == ($past(ctrlTwo_r) | $past(busWdata)))
    else $error("set alias wrong");

  aliasInvert_a: assert property (busWrite && regBase == `OFF_COMPARE && busOp == ccp_pkg::BUS_INVERT
    |=> compare_r == ($past(compare_r) ^ $past(busWdata)))
    else $error("invert alias wrong");

  periodRoll_a: assert property (periodMatch && !tmrWr && !trigStart |-> rollOver)
    else $error("counter did not roll at period");

  countUp_a: assert property (running && !periodMatch && !tmrWr && !trigStart
    |=> counter_r == $past(counter_r) + 32'h0000_0001)
    else $error("counter did not advance");

  trigStart_a: assert property (trigStart && !tmrWr |-> trigFire)
    else $error("trigger did not start time base");

  noRetrig_a: assert property (running && trigActive && !ctl.retrigEn && trigIn && !periodMatch && !tmrWr
    |-> !trigStart ##1 counter_r == $past(counter_r) + 32'h0000_0001)
    else $error("retrigger taken while disabled");

  trigOff_a: assert property (!ctl.triggered_enable |=> !trigActive)
    else $error("trigger status without triggered mode");

  stalledIdle_a: assert property (enabled && ctl.triggered_enable && !trigActive && !trigStart && !tmrWr
    |=> $stable(counter_r))
    else $error("counter ran before trigger");

  postPulse_a: assert property (intOut |-> $past(postWrap) && $past(enabled))
    else $error("interrupt without postscale wrap");

  capLimit_a: assert property (ctl.capSel && postEvt |=> postCnt_r <= 4'h3)
    else $error("capture postscale count too large");

  disClear_a: assert property (!enabled |=> postCnt_r == 4'h0 && !intOut)
    else $error("postscaler active while disabled");

  syncRoll_a: assert property (enabled && !ctl.alternate_sync_select && periodMatch |=> syncOut)
    else $error("sync pulse missing on rollover");

  statusRo_a: assert property (busWrite && regBase == `OFF_STATUS && !(ctl.capSel && captureIn)
    |=> $stable(overflow_r) || !enabled)
    else $error("status changed by write");

endmodule

//--- ccp_params.svh
// Register offsets, field positions, reset values and masks for the capture/compare control block
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses, alias ops in bits 3:2)
`define OFF_CTRL_ONE 8'h00
`define OFF_CTRL_TWO 8'h10
`define OFF_CTRL_THREE 8'h20
`define OFF_STATUS 8'h30
`define OFF_COUNTER 8'h40
`define OFF_PERIOD 8'h50
`define OFF_COMPARE 8'h60
`define OFF_CAPBUF 8'h70

// ==========================================================
// Alias operation codes
`define OP_WRITE 2'h0
`define OP_CLEAR 2'h1
`define OP_SET 2'h2
`define OP_INVERT 2'h3

// ==========================================================
// Reset values and masks
`define RST_CTRL_ONE 32'h0000_0000
`define RST_CTRL_TWO 32'h0100_0000
`define RST_CTRL_THREE 32'h0000_0000
`define RST_PERIOD 32'hffff_ffff
`define MASK_CTRL_ONE 32'hcfff_bfff

// ==========================================================
// Field positions
`define SHOT_CNT_LSB 24
`define STAT_TRIG 7
`define STAT_OVERFLOW 1
`define STAT_NOT_EMPTY 0

`endif

//--- ccp_pkg.sv
// Types shared by the capture/compare control block
package ccp_pkg;

  // ==========================================================
  // First control register layout
  typedef struct packed {
    logic postscaler_source_select;
    logic retrigEn;
    logic [1:0] unused29;
    logic [3:0] postScale;
    logic triggered_enable;
    logic oneShotEn;
    logic alternate_sync_select;
    logic [4:0] syncSel;
    logic modEnable;
    logic unused14;
    logic idleStop;
    logic sleepRun;
    logic tmrSync;
    logic [2:0] clkSel;
    logic [1:0] tmrPs;
    logic t32;
    logic capSel;
    logic [3:0] modeField;
  } ctrlOne_t;

  typedef enum logic [1:0] {
    BUS_WRITE,
    BUS_CLEAR,
    BUS_SET,
    BUS_INVERT
  } busOp_t;

  typedef enum logic {
    TB_FREE,
    TB_TRIGGERED
  } trigState_t;

endpackage

//--- ccp_trigger_postscale_control_tb.sv
// Self-checking testbench for the capture/compare trigger and postscale control block
`timescale 1ns/1ps
`include "ccp_params.svh"

`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module testbench;
  // ==========================================================
  // Stimulus signals
  logic sysClk = 1'b0;
  logic resetN = 1'b0;
  logic [7:0] busAddr = 8'h00;
  logic [31:0] busWdata = 32'h0;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [31:0] busRdata;
  logic trigIn = 1'b0;
  logic captureIn = 1'b0;
  logic altSyncIn = 1'b0;
  logic intOut, syncOut, specialEvt, trigActive;
  int miscompares = 0;
  int testsRun = 0;
  logic [31:0] d, c1, c2;
  logic [31:0] v [4];
  int ni, ns, ne;
  localparam logic [31:0] EN = 32'h0000_8000, CAP = 32'h0000_0010, TRG = 32'h0080_0000;
  localparam logic [31:0] OSH = 32'h0040_0000, ALT = 32'h0020_0000, RTR = 32'h4000_0000;
  localparam logic [31:0] SRC = 32'h8000_0000;
  localparam logic [7:0] OFFS [6] = '{`OFF_CTRL_ONE, `OFF_CTRL_TWO, `OFF_CTRL_THREE, `OFF_PERIOD,
    `OFF_COMPARE, `OFF_COUNTER};
  localparam logic [31:0] RSTS [6] = '{`RST_CTRL_ONE, `RST_CTRL_TWO, `RST_CTRL_THREE, `RST_PERIOD,
    32'h0, 32'h0};

  ccp_trigger_postscale_control #(.ADDR_W(8), .FIFO_DEPTH(4)) DUT (
    .sys_clk(sysClk), .resetn(resetN), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata), .trigIn(trigIn),
    .captureIn(captureIn), .altSyncIn(altSyncIn), .intOut(intOut), .syncOut(syncOut),
    .specialEvt(specialEvt), .trigActive(trigActive)
  );

  initial begin
    forever #12.5 sysClk = ~sysClk;
  end

  // ==========================================================
  // Bus and pin tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sysClk);
    busAddr <= a;
    busWdata <= w;
    busWrite <= 1'b1;
    @(posedge sysClk);
    busWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge sysClk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge sysClk);
    busRead <= 1'b0;
    #1 r = busRdata;
  endtask

  // Ends 1 ns after the edge that samples the trigger
  task automatic trigPulse();
    @(posedge sysClk);
    trigIn <= 1'b1;
    @(posedge sysClk);
    trigIn <= 1'b0;
    #1;
  endtask

  // Window lengths are whole output periods, so counts do not depend on phase
  task automatic pulses(input int n, output int ci, output int cs, output int ce);
    ci = 0;
    cs = 0;
    ce = 0;
    repeat (n) begin
      @(posedge sysClk);
      #1;
      ci += (intOut === 1'b1);
      cs += (syncOut === 1'b1);
      ce += (specialEvt === 1'b1);
    end
  endtask

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sysClk);
    miscompares++;
    endOfTest();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge sysClk);
    resetN <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(OFFS[i], d);
      `CHK("reset value", RSTS[i], d)
    end
    wr(`OFF_CTRL_ONE, 32'hffff_ffff);
    rd(`OFF_CTRL_ONE, d);
    `CHK("ctrl one mask", `MASK_CTRL_ONE, d)
    wr(`OFF_CTRL_ONE, 32'h0);
    wr(`OFF_STATUS, 32'hffff_ffff);
    rd(`OFF_STATUS, d);
    `CHK("status write", 32'h0, d)
    rd(8'h80, d);
    `CHK("unmapped read", 32'h0, d)
    $display("test registers done");

    wr(`OFF_COMPARE, 32'h0000_00f0);
    wr(`OFF_COMPARE | 8'h4, 32'h0000_0030);
    wr(`OFF_COMPARE | 8'h8, 32'h0f00_0001);
    wr(`OFF_COMPARE | 8'hc, 32'hff00_0000);
    rd(`OFF_COMPARE, d);
    `CHK("alias result", 32'hf000_00c1, d)
    rd(`OFF_COMPARE | 8'h4, d);
    `CHK("alias read", 32'h0, d)
    wr(`OFF_COMPARE, 32'h0);
    $display("test aliases done");

    wr(`OFF_PERIOD, 32'd3);
    foreach (OFFS[k]) begin
      automatic logic [3:0] ops = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : (k == 2) ? 4'h3 : 4'hf;
      if (k < 4) begin
        wr(`OFF_CTRL_ONE, 32'h0);
        wr(`OFF_CTRL_ONE, EN | {4'h0, ops, 24'h0});
        repeat (8 * (ops + 1)) @(posedge sysClk);
        pulses(16 * (ops + 1), ni, ns, ne);
        `CHK("postscale ints", 4, ni)
        `CHK("rollover syncs", 4 * (ops + 1), ns)
        `CHK("compare events", 4 * (ops + 1), ne)
      end
    end
    $display("test postscale done");

    wr(`OFF_COMPARE, 32'd10);
    wr(`OFF_CTRL_ONE, EN | SRC);
    repeat (16) @(posedge sysClk);
    pulses(32, ni, ns, ne);
    `CHK("event ints no match", 0, ni)
    wr(`OFF_COMPARE, 32'd2);
    repeat (8) @(posedge sysClk);
    pulses(32, ni, ns, ne);
    `CHK("event ints", 8, ni)
    `CHK("special events", 8, ne)
    $display("test postscale source done");

    wr(`OFF_CTRL_ONE, 32'h0);
    wr(`OFF_PERIOD, 32'hffff_ffff);
    wr(`OFF_CTRL_ONE, EN | CAP | SRC | 32'h0100_0000);
    fork
      repeat (5) begin
        @(posedge sysClk);
        captureIn <= 1'b1;
        @(posedge sysClk);
        captureIn <= 1'b0;
        repeat (4) @(posedge sysClk);
      end
      pulses(40, ni, ns, ne);
    join
    `CHK("capture ints", 2, ni)
    rd(`OFF_STATUS, d);
    `CHK("fifo full flags", 2'b11, d[1:0])
    for (int i = 0; i < 4; i++) rd(`OFF_CAPBUF, v[i]);
    for (int i = 0; i < 3; i++) `CHK("capture spacing", 32'd6, v[i + 1] - v[i])
    rd(`OFF_STATUS, d);
    `CHK("fifo empty", 1'b0, d[0])
    wr(`OFF_CTRL_ONE, 32'h0);
    rd(`OFF_STATUS, d);
    `CHK("overflow cleared", 1'b0, d[1])
    $display("test capture done");

    wr(`OFF_PERIOD, 32'd100);
    wr(`OFF_CTRL_ONE, EN | TRG);
    rd(`OFF_COUNTER, c1);
    rd(`OFF_COUNTER, c2);
    `CHK("untriggered hold", c1, c2)
    `CHK("trigger idle", 1'b0, trigActive)
    trigPulse();
    `CHK("trigger start", 1'b1, trigActive)
    repeat (10) @(posedge sysClk);
    trigPulse();
    rd(`OFF_COUNTER, d);
    `CHK("retrigger refused", 1'b1, d > 32'd5)
    wr(`OFF_CTRL_ONE, EN | TRG | RTR);
    trigPulse();
    rd(`OFF_COUNTER, d);
    `CHK("retrigger taken", 1'b1, d < 32'd5)
    wr(`OFF_CTRL_ONE, EN | RTR);
    wr(`OFF_COUNTER, 32'h0);
    rd(`OFF_COUNTER, c1);
    trigPulse();
    rd(`OFF_COUNTER, c2);
    `CHK("trigger ignored", 32'd4, c2 - c1)
    $display("test trigger done");

    wr(`OFF_PERIOD, 32'd3);
    wr(`OFF_CTRL_ONE, EN | TRG | OSH);
    repeat (20) @(posedge sysClk);
    for (int n = 0; n < 2; n++) begin
      wr(`OFF_CTRL_THREE, n << `SHOT_CNT_LSB);
      trigPulse();
      repeat (5) @(posedge sysClk);
      #1;
      `CHK("one shot running", n == 1, trigActive)
      repeat (4) @(posedge sysClk);
      #1;
      `CHK("one shot ended", 1'b0, trigActive)
    end
    $display("test one shot done");

    wr(`OFF_CTRL_ONE, EN | ALT);
    @(posedge sysClk);
    altSyncIn <= 1'b1;
    repeat (3) @(posedge sysClk);
    #1;
    `CHK("alt sync high", 1'b1, syncOut)
    pulses(8, ni, ns, ne);
    `CHK("alt sync steady", 8, ns)
    altSyncIn <= 1'b0;
    repeat (3) @(posedge sysClk);
    #1;
    `CHK("alt sync low", 1'b0, syncOut)
    $display("test alternate sync done");
    endOfTest();
  end
endmodule
